/* cms_params.svh */
`ifndef CMS_PARAMS_SVH
`define CMS_PARAMS_SVH

// ==================================================================
// Target addresses decoded from the channel/address strap
`define CMS_ADDR_GROUND   7'h34
`define CMS_ADDR_SUPPLY   7'h35
`define CMS_ADDR_FLOAT    7'h36

// ==================================================================
// Level codes from the strap pad sensor
`define CMS_LVL_GROUND    2'h0
`define CMS_LVL_SUPPLY    2'h1
`define CMS_LVL_FLOAT     2'h2
`define CMS_LVL_WEAK_UP   2'h3

// ==================================================================
// Synchroniser bit positions
`define CMS_SYNC_W        8
`define CMS_POS_IFACE     0
`define CMS_POS_STRAP_LO  1
`define CMS_POS_STRAP_HI  2
`define CMS_POS_SCL       3
`define CMS_POS_SDA       4
`define CMS_POS_SNS_CLK   5
`define CMS_POS_AUD_CLK   6
`define CMS_POS_AUD_DAT   7

// ==================================================================
// Cycles after reset release before the straps are caught
`define CMS_SETTLE_CYC    3'h3

`endif

/* cms_pkg.sv */
package cms_pkg;

   // ===============================================================
   // Control mode, one-hot
   typedef enum logic [2:0] {
      CMS_MODE_SW_I2C     = 3'b001,
      CMS_MODE_STANDALONE = 3'b010,
      CMS_MODE_PATTERN    = 3'b100
   } cms_mode_e;

   // ===============================================================
   // Strap capture sequence, one-hot
   typedef enum logic [1:0] {
      CMS_ST_SETTLE = 2'b01,
      CMS_ST_RUN    = 2'b10
   } cms_state_e;

   typedef logic [1:0] cms_level_t;

endpackage : cms_pkg

/* cms_pin_sync.sv */
`timescale 1ns/1ps
`include "cms_params.svh"

module cms_pin_sync (
   input  wire logic                   mclk_in,
   input  wire logic                   arst_n_in,
   input  wire logic [`CMS_SYNC_W-1:0] async_in,
   output logic      [`CMS_SYNC_W-1:0] sync_out,
   output logic      [`CMS_SYNC_W-1:0] sync_dly_out
);

   logic [`CMS_SYNC_W-1:0] meta_r;

   // ================================================================
   // Two stages, plus one more for edge finding downstream
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_r       <= '0;
         sync_out     <= '0;
         sync_dly_out <= '0;
      end else begin
         meta_r       <= async_in;
         sync_out     <= meta_r;
         sync_dly_out <= sync_out;
      end
   end

endmodule : cms_pin_sync

/* cms_mode_select.sv */
// Summary of operation
// - Address strap ground gives 0x34, supply 0x35, floating 0x36.
// - Interface strap at supply starts the audio port in PCM mode.
// - Address strap weakly pulled up, with interface strap at supply, selects standalone mode without I2C.
// - Standalone mode picks the audio slot from static I2C pin levels.
// - Interface strap at ground starts PDM pattern control mode.
// - Pattern mode plays left channel for low strap, right for high.
// - Pattern mode still accepts I2C control when the bus is connected.
// - Sense data leaves on the sense pin in the selected format.
// - Playback audio enters on the audio pin in the selected format.
`timescale 1ns/1ps
`include "cms_params.svh"

module cms_mode_select
   import cms_pkg::*;
(
   input  wire logic       mclk_in,
   input  wire logic       arst_n_in,
   input  wire logic       iface_sel_strap_in,
   input  wire logic [1:0] channel_address_strap_in,
   input  wire logic       i2c_scl_pin_in,
   input  wire logic       i2c_sda_pin_in,
   input  wire logic       sense_clock_frame_sync_pin_in,
   input  wire logic       audio_clock_bit_clock_pin_in,
   input  wire logic       audio_data_in_pin_in,
   input  wire logic       sw_pdm_select_in,
   input  wire logic       sense_pcm_bit_in,
   input  wire logic       sense_pdm_bit_in,
   output logic            cfg_valid_out,
   output logic [2:0]      ctrl_mode_out,
   output logic            pdm_mode_out,
   output logic [6:0]      i2c_addr_out,
   output logic            i2c_enable_out,
   output logic [1:0]      slot_select_out,
   output logic            pdm_right_chan_out,
   output logic            audio_bit_out,
   output logic            audio_bit_valid_out,
   output logic            frame_sync_out,
   output logic            sense_bit_req_out,
   output logic            sense_data_out_pin_out
);

   // ================================================================
   // Decode helpers
   function automatic logic [6:0] cms_addr_f(input cms_level_t lvl);
      logic [6:0] a;
      a = `CMS_ADDR_SUPPLY;
      if (lvl == `CMS_LVL_GROUND)
         a = `CMS_ADDR_GROUND;
      else if (lvl == `CMS_LVL_FLOAT)
         a = `CMS_ADDR_FLOAT;
      return a;
   endfunction : cms_addr_f

   function automatic logic [2:0] cms_mode_f(input logic iface, input cms_level_t lvl);
      logic [2:0] m;
      m = CMS_MODE_SW_I2C;
      if (!iface)
         m = CMS_MODE_PATTERN;
      else if (lvl == `CMS_LVL_WEAK_UP)
         m = CMS_MODE_STANDALONE;
      return m;
   endfunction : cms_mode_f

   // ================================================================
   // Pin synchronisers
   logic [`CMS_SYNC_W-1:0] pins_w;
   logic [`CMS_SYNC_W-1:0] sync_w;
   logic [`CMS_SYNC_W-1:0] dly_w;

   assign pins_w = {audio_data_in_pin_in, audio_clock_bit_clock_pin_in, sense_clock_frame_sync_pin_in,
                    i2c_sda_pin_in, i2c_scl_pin_in, channel_address_strap_in, iface_sel_strap_in};

   cms_pin_sync u_sync (
      .mclk_in      (mclk_in),
      .arst_n_in    (arst_n_in),
      .async_in     (pins_w),
      .sync_out     (sync_w),
      .sync_dly_out (dly_w)
   );

   // ================================================================
   // Capture sequence
   cms_state_e  state_r;
   cms_state_e  state_nxt;
   logic [2:0]  settle_r;
   logic [2:0]  settle_nxt;
   cms_level_t  strap_cap_r;
   logic        iface_cap_r;
   logic [1:0]  slot_cap_r;
   logic        capture_w;

   assign capture_w = (state_r == CMS_ST_SETTLE) && (settle_r == `CMS_SETTLE_CYC);

   // Wait for the synchronisers to fill before trusting the straps
   always_comb begin
      state_nxt  = state_r;
      settle_nxt = settle_r;
      unique case (state_r)
         CMS_ST_SETTLE: begin
            settle_nxt = settle_r + 3'h1;
            if (capture_w) begin
               state_nxt = CMS_ST_RUN;
            end
         end
         CMS_ST_RUN: begin
            settle_nxt = settle_r;
         end
      endcase
   end

   // Straps caught once; later pin changes are ignored
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_r     <= CMS_ST_SETTLE;
         settle_r    <= 3'h0;
         strap_cap_r <= `CMS_LVL_GROUND;
         iface_cap_r <= 1'b0;
         slot_cap_r  <= 2'h0;
      end else begin
         state_r  <= state_nxt;
         settle_r <= settle_nxt;
         if (capture_w) begin
            strap_cap_r <= sync_w[`CMS_POS_STRAP_HI:`CMS_POS_STRAP_LO];
            iface_cap_r <= sync_w[`CMS_POS_IFACE];
            slot_cap_r  <= {sync_w[`CMS_POS_SDA], sync_w[`CMS_POS_SCL]};
         end
      end
   end

   // ================================================================
   // Configuration decode
   logic        run_w;
   logic [2:0]  mode_w;
   logic        pdm_w;
   logic        right_w;

   assign run_w   = (state_r == CMS_ST_RUN);
   assign mode_w  = cms_mode_f(iface_cap_r, strap_cap_r);
   // PCM by default; software may move to PDM only in its own mode
   assign pdm_w   = (mode_w == CMS_MODE_PATTERN) ||
                    ((mode_w == CMS_MODE_SW_I2C) && sw_pdm_select_in);
   // Floating reads as low for channel choice
   assign right_w = (strap_cap_r == `CMS_LVL_SUPPLY) || (strap_cap_r == `CMS_LVL_WEAK_UP);

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cfg_valid_out      <= 1'b0;
         ctrl_mode_out      <= 3'h0;
         pdm_mode_out       <= 1'b0;
         i2c_addr_out       <= 7'h00;
         i2c_enable_out     <= 1'b0;
         slot_select_out    <= 2'h0;
         pdm_right_chan_out <= 1'b0;
      end else begin
         cfg_valid_out      <= run_w;
         ctrl_mode_out      <= run_w ? mode_w : 3'h0;
         pdm_mode_out       <= run_w && pdm_w;
         i2c_addr_out       <= run_w ? cms_addr_f(strap_cap_r) : 7'h00;
         i2c_enable_out     <= run_w && (mode_w != CMS_MODE_STANDALONE);
         slot_select_out    <= (run_w && mode_w == CMS_MODE_STANDALONE) ? slot_cap_r : 2'h0;
         pdm_right_chan_out <= run_w && (mode_w == CMS_MODE_PATTERN) && right_w;
      end
   end

   // ================================================================
   // Clock edges found on the sampled host clocks
   logic aud_rise_w;
   logic aud_fall_w;
   logic sns_fall_w;
   logic take_audio_w;
   logic drive_sense_w;
   logic sense_bit_w;

   assign aud_rise_w = sync_w[`CMS_POS_AUD_CLK] & ~dly_w[`CMS_POS_AUD_CLK];
   assign aud_fall_w = ~sync_w[`CMS_POS_AUD_CLK] & dly_w[`CMS_POS_AUD_CLK];
   assign sns_fall_w = ~sync_w[`CMS_POS_SNS_CLK] & dly_w[`CMS_POS_SNS_CLK];

   // PDM left rides the rising audio clock edge, right the falling one
   assign take_audio_w  = cfg_valid_out &&
                          (pdm_mode_out ? (pdm_right_chan_out ? aud_fall_w : aud_rise_w) : aud_rise_w);
   // PCM sense data moves on falling bit clock, PDM on falling sense clock
   assign drive_sense_w = cfg_valid_out && (pdm_mode_out ? sns_fall_w : aud_fall_w);
   assign sense_bit_w   = pdm_mode_out ? sense_pdm_bit_in : sense_pcm_bit_in;

   // Data pin shares the clock pin's delay, so alignment holds
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         audio_bit_out          <= 1'b0;
         audio_bit_valid_out    <= 1'b0;
         frame_sync_out         <= 1'b0;
         sense_bit_req_out      <= 1'b0;
         sense_data_out_pin_out <= 1'b0;
      end else begin
         audio_bit_valid_out <= take_audio_w;
         sense_bit_req_out   <= drive_sense_w;
         if (take_audio_w) begin
            audio_bit_out  <= sync_w[`CMS_POS_AUD_DAT];
            frame_sync_out <= !pdm_mode_out && sync_w[`CMS_POS_SNS_CLK];
         end
         if (drive_sense_w) begin
            sense_data_out_pin_out <= sense_bit_w;
         end
      end
   end

   // ================================================================
   // Checks
   a_addr_decode: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      cfg_valid_out |-> i2c_addr_out == ((strap_cap_r == `CMS_LVL_GROUND) ? 7'h34 :
                                         (strap_cap_r == `CMS_LVL_FLOAT) ? 7'h36 : 7'h35))
      else $error("address decode wrong");

   a_pcm_default: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (run_w && iface_cap_r && !sw_pdm_select_in) |=> !pdm_mode_out)
      else $error("PCM default not kept");

   a_sw_pdm_switch: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (run_w && mode_w == CMS_MODE_SW_I2C && sw_pdm_select_in) |=> pdm_mode_out)
      else $error("software PDM switch ignored");

   a_standalone_nobus: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (cfg_valid_out && iface_cap_r && strap_cap_r == `CMS_LVL_WEAK_UP) |->
         (ctrl_mode_out == CMS_MODE_STANDALONE) && !i2c_enable_out)
      else $error("standalone mode not entered");

   a_slot_static: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (ctrl_mode_out == CMS_MODE_STANDALONE) |-> slot_select_out == slot_cap_r)
      else $error("slot select not from pins");

   a_pattern_pdm: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (cfg_valid_out && !iface_cap_r) |-> pdm_mode_out && ctrl_mode_out == CMS_MODE_PATTERN)
      else $error("pattern mode not PDM");

   a_chan_select: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (ctrl_mode_out == CMS_MODE_PATTERN) |-> pdm_right_chan_out == right_w)
      else $error("channel select wrong");

   a_pattern_i2c: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (ctrl_mode_out == CMS_MODE_PATTERN) |-> i2c_enable_out)
      else $error("I2C lost in pattern mode");

   a_sense_drive: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      sense_bit_req_out |-> sense_data_out_pin_out == $past(sense_bit_w))
      else $error("sense bit not driven");

   a_audio_take: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      audio_bit_valid_out |-> audio_bit_out == $past(sync_w[`CMS_POS_AUD_DAT]) && $past(cfg_valid_out))
      else $error("audio bit not taken");

   a_mode_hold: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (cfg_valid_out && $past(cfg_valid_out)) |-> $stable(ctrl_mode_out) && $stable(i2c_addr_out))
      else $error("mode changed after capture");

endmodule : cms_mode_select

/* cms_host_model.sv */
`timescale 1ns/1ps

// ==========================================================
// Host side: clock master for both serial ports
module cms_host_model (
   input  wire logic run_in,
   input  wire logic pdm_in,
   input  wire logic right_in,
   input  wire logic bit_in,
   output logic      fs_sck_out,
   output logic      bck_out,
   output logic      dat_out,
   output logic      smp_tgl_out,
   output logic      smp_bit_out,
   output logic      smp_fs_out
);
   logic [2:0] cnt;

   // Sampling edge notes the bit, the other edge moves the data
   task automatic act(input logic smp);
      if (smp) begin
         smp_bit_out = dat_out;
         smp_fs_out  = fs_sck_out & ~pdm_in;
         smp_tgl_out = ~smp_tgl_out;
      end else begin
         dat_out = bit_in;
      end
   endtask : act

   // Clocks stand still low between bursts; data flips so a stale bit never passes
   initial begin
      {fs_sck_out, bck_out, dat_out, smp_tgl_out, smp_bit_out, smp_fs_out} = 6'h0;
      cnt = 3'h0;
      forever begin
         // An unknown run level at time zero counts as stopped, so no burst leaks into reset
         if (run_in !== 1'b1) begin
            fs_sck_out = 1'b0;
            bck_out = 1'b0;
            dat_out = ~dat_out;
            wait (run_in === 1'b1);
            #2; // Keeps pin edges off the system clock edges
         end
         #40;
         bck_out = 1'b1;
         act(!right_in);
         #40;
         if (pdm_in) fs_sck_out = 1'b1; // Separate sense clock
         #40;
         bck_out = 1'b0;
         act(right_in);
         cnt = cnt + 3'h1;
         if (!pdm_in && cnt == 3'h0) fs_sck_out = ~fs_sck_out; // Frame sync
         #40;
         if (pdm_in) fs_sck_out = 1'b0;
      end
   end
endmodule : cms_host_model

/* control_mode_strap_select_bench.sv */
`timescale 1ns/1ps
`include "cms_params.svh"

module control_mode_strap_select_bench import cms_pkg::*; ;
   logic mclk_in, arst_n, iface, scl, sda, sw, sp, sd, run, pdm, right, bitn, cv_d;
   logic [1:0] strap, nb;
   logic       fs_sck, bck, dat, tgl, s_bit, s_fs;
   logic       cfg_v, pdm_o, i2c_en, right_o, a_bit, a_vld, fs_o, s_req, s_pin;
   logic [2:0] mode_o;
   logic [6:0] addr_o;
   logic [1:0] slot_o;
   logic [14:0] cq[$];
   logic [1:0]  aq[$];
   logic        sq[$];
   integer      seed, miscompares, check_count;
   logic [15:0] cfg_exp;
   wire  [14:0] cfg_seen = {mode_o, pdm_o, addr_o, i2c_en, slot_o, right_o};

   cms_mode_select cms_mode_select_inst (.mclk_in(mclk_in), .arst_n_in(arst_n), .iface_sel_strap_in(iface),
      .channel_address_strap_in(strap), .i2c_scl_pin_in(scl), .i2c_sda_pin_in(sda),
      .sense_clock_frame_sync_pin_in(fs_sck), .audio_clock_bit_clock_pin_in(bck), .audio_data_in_pin_in(dat),
      .sw_pdm_select_in(sw), .sense_pcm_bit_in(sp), .sense_pdm_bit_in(sd), .cfg_valid_out(cfg_v),
      .ctrl_mode_out(mode_o), .pdm_mode_out(pdm_o), .i2c_addr_out(addr_o), .i2c_enable_out(i2c_en),
      .slot_select_out(slot_o), .pdm_right_chan_out(right_o), .audio_bit_out(a_bit),
      .audio_bit_valid_out(a_vld), .frame_sync_out(fs_o), .sense_bit_req_out(s_req),
      .sense_data_out_pin_out(s_pin));

   cms_host_model cms_host_model_inst (.run_in(run), .pdm_in(pdm), .right_in(right), .bit_in(bitn),
      .fs_sck_out(fs_sck), .bck_out(bck), .dat_out(dat), .smp_tgl_out(tgl), .smp_bit_out(s_bit),
      .smp_fs_out(s_fs));

   // ==========================================================
   // Checking and verdict
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize();
      if (miscompares == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize

   // Decoded configuration worked out from the strap levels
   function automatic logic [14:0] expect_cfg(input logic ifc, input logic [1:0] lv, input logic c, input logic d);
      logic [6:0] a;
      a = (lv == `CMS_LVL_GROUND) ? `CMS_ADDR_GROUND : (lv == `CMS_LVL_FLOAT) ? `CMS_ADDR_FLOAT : `CMS_ADDR_SUPPLY;
      if (!ifc) return {CMS_MODE_PATTERN, 1'b1, a, 1'b1, 2'h0, lv[0]};
      if (lv == `CMS_LVL_WEAK_UP) return {CMS_MODE_STANDALONE, 1'b0, a, 1'b0, d, c, 1'b0};
      return {CMS_MODE_SW_I2C, 1'b0, a, 1'b1, 2'h0, 1'b0};
   endfunction : expect_cfg

   // ==========================================================
   // One strap setting: reset, capture, traffic, hold, software switch
   task automatic run_case(input int i);
      logic [14:0] e;
      logic        c, d, f;
      logic [1:0]  lv;
      c = 1'($random(seed));
      d = 1'($random(seed));
      f = (i < 4) || (i >= 8);
      lv = (i < 8) ? 2'(i) : `CMS_LVL_WEAK_UP;
      e = expect_cfg(f, lv, c, d);
      @(posedge mclk_in);
      arst_n <= 1'b0;
      {iface, strap, scl, sda} <= {f, lv, c, d};
      nb = 2'($random(seed));
      {sd, sp} <= nb;
      cq.delete();
      aq.delete();
      sq.delete();
      cq.push_back(e);
      sq.push_back(e[11] ? nb[1] : nb[0]);
      pdm = e[11];
      right = e[0];
      repeat (20) @(posedge mclk_in);
      arst_n <= 1'b1;
      repeat (10) @(posedge mclk_in);
      check(16'(cq.size()), 16'h0);
      {iface, strap, scl, sda} <= 5'($random(seed)); // Late strap moves must be ignored
      run <= 1'b1;
      repeat (768) @(posedge mclk_in);
      run <= 1'b0;
      repeat (20) @(posedge mclk_in);
      check(16'(cfg_seen), 16'(e));
      check(16'(aq.size()), 16'h0);
      check(16'(sq.size()), 16'h1);
      sw <= 1'b1;
      repeat (2) @(posedge mclk_in);
      check(16'(pdm_o), 16'(e[11] | (e[14:12] == CMS_MODE_SW_I2C)));
      sw <= 1'b0;
      @(posedge mclk_in);
   endtask : run_case

   // ==========================================================
   // Clock, random audio source, sense source
   initial begin
      mclk_in = 1'b0;
      forever #2.5 mclk_in = ~mclk_in;
   end

   always @(posedge mclk_in) bitn <= 1'($random(seed));

   // Source moves its bits only after each request
   always @(posedge mclk_in) if (s_req === 1'b1) begin
      nb = 2'($random(seed));
      {sd, sp} <= nb;
      sq.push_back(pdm ? nb[1] : nb[0]);
   end

   always @(tgl) aq.push_back({s_fs, s_bit});

   // ==========================================================
   // Watchers take the oldest note whenever a result appears
   always @(posedge mclk_in) begin
      if (cfg_v === 1'b1 && cv_d !== 1'b1) begin
         cfg_exp = (cq.size() != 0) ? 16'(cq.pop_front()) : 16'hffff;
         check(16'(cfg_seen), cfg_exp);
      end
      if (a_vld === 1'b1)
         check(16'({fs_o, a_bit}), (aq.size() != 0) ? 16'(aq.pop_front()) : 16'hffff);
      if (s_req === 1'b1)
         check(16'(s_pin), (sq.size() != 0) ? 16'(sq.pop_front()) : 16'hffff);
      cv_d <= cfg_v;
   end

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      seed = 19;
      miscompares = 0;
      check_count = 0;
      {arst_n, iface, strap, scl, sda, sw, sp, sd, run, pdm, right, bitn, cv_d, nb} = 16'h0;
      for (int i = 0; i < 11; i++) run_case(i);
      summarize();
   end

   initial begin
      #200000;
      miscompares = miscompares + 1;
      summarize();
   end
endmodule : control_mode_strap_select_bench
